// [common/playback_gain_path_consts.svh]
`ifndef PLAYBACK_GAIN_PATH_CONSTS_SVH
`define PLAYBACK_GAIN_PATH_CONSTS_SVH
`define VOL_MAX_CODE 8'hc8
`define VOL_RESET 8'h00
`define RAMP_1 2'b00
`define RAMP_4 2'b01
`define RAMP_8 2'b10
`define RAMP_OFF 2'b11
`define RAMP_PER_1 4'h1
`define RAMP_PER_4 4'h4
`define RAMP_PER_8 4'h8
`define HPF_BYPASS 3'b000
`define HPF_RESET 3'b001
`define HPF_RESERVED 3'b111
`define LEVEL_RESET 5'h10
`define LEVEL_MAX 5'h14
`define SRC_PCM 1'b0
`define SRC_PDM 1'b1
`define REG_CTRL 4'h0
`define REG_PCM_VOL 4'h1
`define REG_PDM_VOL 4'h2
`define REG_LEVEL 4'h3
`define REG_STATUS 4'h4
`define REG_PCM_APPLIED 4'h5
`define REG_PDM_APPLIED 4'h6
// Control register fields
`define CTRL_HPF_LSB 0
`define CTRL_RAMP_LSB 3
`define CTRL_SRC_BIT 5
// Attenuation table: gain per 6 dB octave, 0.5 dB fraction steps (Q15)
`define GAIN_ONE 16'h8000
`endif

// [common/playback_gain_path_pkg.sv]
package playback_gain_path_pkg;
  typedef logic [7:0] vol_code_t;
  typedef logic [2:0] hpf_sel_t;
  typedef logic [1:0] ramp_sel_t;
  typedef logic [4:0] level_code_t;
endpackage

// [rtl/sample_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("sample_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_reg != rd_reg;
  assign out_data_o = mem[rd_reg[AW-1:0]];
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [rtl/playback_gain_path.sv]
// Overview of operation
// RULE_01 - Highpass filter on PCM path only
// RULE_02 - Corner code zero bypasses the filter
// RULE_03 - Corner codes select 2 to 800 Hz
// RULE_04 - Separate volume for PCM and PDM
// RULE_05 - Volume code attenuates half dB per count
// RULE_06 - Codes above 0xc8 mute the path
// RULE_07 - Volume changes ramp toward new code
// RULE_08 - Ramp step every 1, 4, 8 samples
// RULE_09 - Ramp code 11 applies volume directly
// RULE_10 - Output level code sets full scale
// RULE_11 - Output equals input plus volume plus level
// RULE_12 - Source select picks PCM or PDM
// RULE_13 - Settings change only at sample boundaries; the code drives level_reg to amp_level_o as soon as it is written
//
// Added by the designer: strobed register access and the register addresses.
`include "playback_gain_path_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module playback_gain_path #(
  parameter int WIDTH = 24,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [WIDTH-1:0] pcm_data_i,
  input wire logic pcm_valid_i,
  output logic pcm_ready_o,
  input wire logic [WIDTH-1:0] pdm_data_i,
  input wire logic pdm_valid_i,
  output logic pdm_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [4:0] amp_level_o
);
  initial
  begin
    if (WIDTH < 16 || WIDTH > 32)
      $error("playback_gain_path width out of range");
  end
  localparam int AW = WIDTH + 16;

  // Registers
  playback_gain_path_pkg::hpf_sel_t highpass_corner_sel_reg;
  playback_gain_path_pkg::ramp_sel_t ramp_rate_reg;
  logic playback_source_sel_reg;
  playback_gain_path_pkg::vol_code_t pcm_volume_code_reg;
  playback_gain_path_pkg::vol_code_t pdm_volume_code_reg;
  playback_gain_path_pkg::level_code_t level_reg;
  // Values latched at sample boundary; rdata_reg is latched every clock, from the read mux during a read and zero otherwise
  playback_gain_path_pkg::hpf_sel_t hpf_act_reg;
  playback_gain_path_pkg::vol_code_t pcm_applied_reg;
  playback_gain_path_pkg::vol_code_t pdm_applied_reg;
  logic [3:0] ramp_cnt_reg;
  logic signed [WIDTH-1:0] prev_in_reg;
  logic signed [AW-1:0] hpf_y_reg;
  logic [7:0] rdata_reg;

  // Attenuation: 6 dB per 12 codes is a shift, the remainder a table
  function automatic logic [15:0] frac_gain(input logic [3:0] r);
    case (r)
      4'h0: frac_gain = 16'h8000;
      4'h1: frac_gain = 16'h78d6;
      4'h2: frac_gain = 16'h7214;
      4'h3: frac_gain = 16'h6bb2;
      4'h4: frac_gain = 16'h65ac;
      4'h5: frac_gain = 16'h5ffc;
      4'h6: frac_gain = 16'h5a9d;
      4'h7: frac_gain = 16'h558c;
      4'h8: frac_gain = 16'h50c3;
      4'h9: frac_gain = 16'h4c3e;
      4'ha: frac_gain = 16'h47fa;
      4'hb: frac_gain = 16'h43f4;
      default: frac_gain = 16'h0000;
    endcase
  endfunction

  function automatic logic signed [WIDTH-1:0] apply_vol(
    input logic signed [WIDTH-1:0] s, input logic [7:0] code);
    logic signed [AW-1:0] prod;
    logic [4:0] shift;
    logic [3:0] rem;
    prod = '0;
    shift = 5'(code / 8'd12);
    rem = 4'(code % 8'd12);
    if (code > `VOL_MAX_CODE) // [RULE_06]
      apply_vol = '0;
    else
    begin
      prod = AW'(s) * $signed({1'b0, frac_gain(rem)}); // [RULE_05]
      prod = prod >>> (15 + shift);
      apply_vol = prod[WIDTH-1:0];
    end
  endfunction

  // One-pole DC blocker; pole set by shift k
  function automatic logic [3:0] hpf_shift(input logic [2:0] sel);
    case (sel)
      3'b001: hpf_shift = 4'd13;
      3'b010: hpf_shift = 4'd8;
      3'b011: hpf_shift = 4'd7;
      3'b100: hpf_shift = 4'd6;
      3'b101: hpf_shift = 4'd5;
      3'b110: hpf_shift = 4'd4;
      default: hpf_shift = 4'd13;
    endcase
  endfunction

  function automatic logic [7:0] ramp_step(
    input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      ramp_step = cur + 8'h01;
    else if (cur > tgt)
      ramp_step = cur - 8'h01;
    else
      ramp_step = cur;
  endfunction

  // Input FIFO for the selected source
  // Each word carries its source bit, so words already queued keep
  // their own path across a source switch
  logic [WIDTH:0] fifo_in_data;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [WIDTH:0] fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  assign fifo_in_data = playback_source_sel_reg
                        ? {`SRC_PDM, pdm_data_i}
                        : {`SRC_PCM, pcm_data_i};
  assign fifo_in_valid = playback_source_sel_reg ? pdm_valid_i
                                                 : pcm_valid_i; // [RULE_12]
  assign pcm_ready_o = !playback_source_sel_reg && fifo_in_ready;
  assign pdm_ready_o = playback_source_sel_reg && fifo_in_ready;

  sample_fifo #(.WIDTH(WIDTH + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(fifo_in_data),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );

  // Sample boundary: one sample processed per FIFO pop
  wire sample_go = fifo_valid && fifo_ready;
  assign fifo_ready = !out_valid_o || out_ready_i;

  wire src_word = fifo_data[WIDTH];
  wire signed [WIDTH-1:0] x = fifo_data[WIDTH-1:0];
  wire [3:0] k = hpf_shift(hpf_act_reg);
  wire signed [AW-1:0] hpf_sum = hpf_y_reg + AW'(x) - AW'(prev_in_reg)
                                  - (hpf_y_reg >>> k);
  wire hpf_on = (src_word == `SRC_PCM) && (hpf_act_reg != `HPF_BYPASS);
  wire signed [WIDTH-1:0] hpf_out = hpf_on ? hpf_sum[WIDTH-1:0]
                                           : x; // [RULE_01] [RULE_02] [RULE_03]
  wire [7:0] vol_use = (src_word == `SRC_PDM) ? pdm_applied_reg
                                                 : pcm_applied_reg; // [RULE_04]
  wire signed [WIDTH-1:0] vol_out = apply_vol(hpf_out, vol_use); // [RULE_11]

  wire [3:0] ramp_per = (ramp_rate_reg == `RAMP_4) ? `RAMP_PER_4 :
                        (ramp_rate_reg == `RAMP_8) ? `RAMP_PER_8 : `RAMP_PER_1;
  wire ramp_tick = (ramp_cnt_reg + 4'h1) >= ramp_per; // [RULE_08]
  wire ramp_off = ramp_rate_reg == `RAMP_OFF;

  // Register decode
  wire wr_ctrl = reg_wr_i && reg_addr_i == `REG_CTRL;
  wire wr_pcm = reg_wr_i && reg_addr_i == `REG_PCM_VOL;
  wire wr_pdm = reg_wr_i && reg_addr_i == `REG_PDM_VOL;
  wire wr_lvl = reg_wr_i && reg_addr_i == `REG_LEVEL;
  wire [7:0] ctrl_val = {2'b00, playback_source_sel_reg, ramp_rate_reg,
                         highpass_corner_sel_reg};
  wire [7:0] rd_mux =
    (reg_addr_i == `REG_CTRL) ? ctrl_val :
    (reg_addr_i == `REG_PCM_VOL) ? pcm_volume_code_reg :
    (reg_addr_i == `REG_PDM_VOL) ? pdm_volume_code_reg :
    (reg_addr_i == `REG_LEVEL) ? {3'b000, level_reg} :
    (reg_addr_i == `REG_STATUS) ? {6'h00, fifo_valid, !fifo_in_ready} :
    (reg_addr_i == `REG_PCM_APPLIED) ? pcm_applied_reg :
    (reg_addr_i == `REG_PDM_APPLIED) ? pdm_applied_reg : 8'h00;
  assign reg_rdata_o = rdata_reg;
  assign amp_level_o = level_reg; // [RULE_10]

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      highpass_corner_sel_reg <= `HPF_RESET;
      ramp_rate_reg <= `RAMP_1;
      playback_source_sel_reg <= `SRC_PCM;
      pcm_volume_code_reg <= `VOL_RESET;
      pdm_volume_code_reg <= `VOL_RESET;
      level_reg <= `LEVEL_RESET;
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
      if (wr_ctrl)
      begin
        if (reg_wdata_i[`CTRL_HPF_LSB +: 3] != `HPF_RESERVED)
          highpass_corner_sel_reg <= reg_wdata_i[`CTRL_HPF_LSB +: 3];
        ramp_rate_reg <= reg_wdata_i[`CTRL_RAMP_LSB +: 2];
        playback_source_sel_reg <= reg_wdata_i[`CTRL_SRC_BIT];
      end
      if (wr_pcm)
        pcm_volume_code_reg <= reg_wdata_i;
      if (wr_pdm)
        pdm_volume_code_reg <= reg_wdata_i;
      if (wr_lvl && reg_wdata_i[4:0] <= `LEVEL_MAX)
        level_reg <= reg_wdata_i[4:0];
    end
  end

  // Sample-boundary updates of applied settings and filter state
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      hpf_act_reg <= `HPF_RESET;
      pcm_applied_reg <= `VOL_RESET;
      pdm_applied_reg <= `VOL_RESET;
      ramp_cnt_reg <= 4'h0;
      prev_in_reg <= '0;
      hpf_y_reg <= '0;
    end
    else if (sample_go) // [RULE_13]
    begin
      hpf_act_reg <= highpass_corner_sel_reg;
      prev_in_reg <= x;
      hpf_y_reg <= hpf_on ? hpf_sum : '0;
      ramp_cnt_reg <= ramp_tick ? 4'h0 : ramp_cnt_reg + 4'h1;
      if (ramp_off) // [RULE_09]
      begin
        pcm_applied_reg <= pcm_volume_code_reg;
        pdm_applied_reg <= pdm_volume_code_reg;
      end
      else if (ramp_tick) // [RULE_07]
      begin
        pcm_applied_reg <= ramp_step(pcm_applied_reg, pcm_volume_code_reg);
        pdm_applied_reg <= ramp_step(pdm_applied_reg, pdm_volume_code_reg);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (fifo_ready)
    begin
      out_valid_o <= fifo_valid;
      if (fifo_valid)
        out_data_o <= vol_out;
    end
  end
endmodule
`default_nettype wire

// [bench/sample_source.sv]
`timescale 1ns/10ps
`default_nettype none
module sample_source #(
  parameter int WIDTH = 24
) (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [WIDTH-1:0] data_o,
  output logic valid_o
);
  initial
  begin
    valid_o = 1'b0;
    data_o = '0;
  end
  // Holds the word until it is taken or 200 more cycles pass
  task automatic send(input logic [WIDTH-1:0] w);
    int n;
    n = 0;
    valid_o <= 1'b1;
    data_o <= w;
    @(posedge clk_i);
    while (ready_i !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Released data shows the inverse of the last word
  task automatic idle();
    valid_o <= 1'b0;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

// [bench/playback_gain_path_sva.sv]
`timescale 1ns/10ps
`default_nettype none
`include "playback_gain_path_consts.svh"
module gain_path_sva #(
  parameter int WIDTH = 24
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic pcm_ready_o,
  input wire logic pdm_ready_o,
  input wire logic [WIDTH-1:0] out_data_o,
  input wire logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic [4:0] amp_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire lvl_wr = reg_wr_i && reg_addr_i == `REG_LEVEL;
  wire ctl_wr = reg_wr_i && reg_addr_i == `REG_CTRL;
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside answer");
  a_unmapped_rd: assert property (reg_rd_i && reg_addr_i > 4'h6
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_level_take: assert property (lvl_wr
    && reg_wdata_i[4:0] <= `LEVEL_MAX
    |=> amp_level_o == $past(reg_wdata_i[4:0])) else $error("level lost");
  a_level_keep: assert property (lvl_wr
    && reg_wdata_i[4:0] > `LEVEL_MAX
    |=> $stable(amp_level_o)) else $error("reserved level taken");
  a_level_range: assert property (amp_level_o <= `LEVEL_MAX)
    else $error("level above range");
  a_one_source: assert property (!(pcm_ready_o && pdm_ready_o))
    else $error("both sources ready");
  a_pdm_pick: assert property (ctl_wr && reg_wdata_i[5]
    |=> !pcm_ready_o) else $error("pcm ready with pdm chosen");
  a_pcm_pick: assert property (ctl_wr && !reg_wdata_i[5]
    |=> !pdm_ready_o) else $error("pdm ready with pcm chosen");
  a_out_hold: assert property (out_valid_o && !out_ready_i
    |=> out_valid_o && $stable(out_data_o)) else $error("output dropped");
  c_level_refused: cover property (lvl_wr && reg_wdata_i[4:0] > `LEVEL_MAX);
  c_out_stall: cover property (out_valid_o && !out_ready_i);
  c_pdm_ready: cover property (pdm_ready_o);
endmodule
bind playback_gain_path gain_path_sva #(.WIDTH(WIDTH)) u_sva (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pcm_ready_o(pcm_ready_o),
  .pdm_ready_o(pdm_ready_o), .out_data_o(out_data_o),
  .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .amp_level_o(amp_level_o));
`default_nettype wire

// [bench/playback_gain_path_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "playback_gain_path_consts.svh"
module playback_gain_path_tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic out_ready_i = 1'b1;
  logic [7:0] reg_rdata_o;
  logic [23:0] pcm_d, pdm_d, out_data_o;
  logic pcm_v, pdm_v, pcm_ready_o, pdm_ready_o, out_valid_o;
  logic [4:0] amp_level_o;
  logic [23:0] got_q[$];
  logic [23:0] last_w;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  playback_gain_path u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pcm_data_i(pcm_d), .pcm_valid_i(pcm_v), .pcm_ready_o(pcm_ready_o),
    .pdm_data_i(pdm_d), .pdm_valid_i(pdm_v), .pdm_ready_o(pdm_ready_o),
    .out_data_o(out_data_o), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .amp_level_o(amp_level_o));
  sample_source u_pcm (.clk_i(clk_i), .ready_i(pcm_ready_o),
    .data_o(pcm_d), .valid_o(pcm_v));
  sample_source u_pdm (.clk_i(clk_i), .ready_i(pdm_ready_o),
    .data_o(pdm_d), .valid_o(pdm_v));
  always @(posedge clk_i)
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      got_q.push_back(out_data_o);
  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] e);
    n_compared++;
    if (got !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    check({16'h0, reg_rdata_o}, {16'h0, e});
  endtask
  // Waits for one output word; c says whether it is compared
  task automatic take(input logic [23:0] e, input bit c);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    if (got_q.size() == 0)
      check(24'hx, e);
    else
    begin
      last_w = got_q.pop_front();
      if (c)
        check(last_w, e);
    end
  endtask
  task automatic xfer(input bit pdm, input logic [23:0] w, e, input bit c);
    if (pdm)
      u_pdm.send(w);
    else
      u_pcm.send(w);
    u_pdm.idle();
    u_pcm.idle();
    take(e, c);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    check({19'h0, amp_level_o}, 24'h10);
    rchk(`REG_CTRL, 8'h01);
    rchk(`REG_PCM_VOL, 8'h00);
    rchk(`REG_PDM_VOL, 8'h00);
    rchk(`REG_LEVEL, 8'h10);
    wr(`REG_CTRL, 8'h1f);
    rchk(`REG_CTRL, 8'h19);
    wr(`REG_LEVEL, 8'h14);
    wr(`REG_LEVEL, 8'h15);
    rchk(`REG_LEVEL, 8'h14);
    check({19'h0, amp_level_o}, 24'h14);
    rchk(4'hf, 8'h00);
    $display("registers done");
    wr(`REG_CTRL, 8'h18);
    xfer(1'b0, 24'h0, 24'h0, 1'b0);
    xfer(1'b0, 24'h100000, 24'h100000, 1'b1);
    wr(`REG_PCM_VOL, 8'h0c);
    xfer(1'b0, 24'h0, 24'h0, 1'b0);
    xfer(1'b0, 24'h100000, 24'h080000, 1'b1);
    wr(`REG_PCM_VOL, 8'hc9);
    xfer(1'b0, 24'h0, 24'h0, 1'b0);
    xfer(1'b0, 24'h123456, 24'h0, 1'b1);
    rchk(`REG_PCM_APPLIED, 8'hc9);
    $display("volume done");
    for (int i = 0; i < 3; i++)
    begin
      wr(`REG_CTRL, 8'h18);
      wr(`REG_PCM_VOL, 8'h00);
      repeat (2) xfer(1'b0, 24'h0, 24'h0, 1'b0);
      wr(`REG_CTRL, 8'(i * 8));
      xfer(1'b0, 24'h0, 24'h0, 1'b0);
      wr(`REG_PCM_VOL, 8'h10);
      repeat (8) xfer(1'b0, 24'h0, 24'h0, 1'b0);
      rchk(`REG_PCM_APPLIED, 8'(8 / (i == 0 ? 1 : 4 * i)));
    end
    $display("ramp done");
    wr(`REG_CTRL, 8'h21);
    wr(`REG_PCM_VOL, 8'hc9);
    check({23'h0, pcm_ready_o}, 24'h0);
    xfer(1'b1, 24'h0, 24'h0, 1'b0);
    xfer(1'b1, 24'h200000, 24'h200000, 1'b1);
    xfer(1'b1, 24'h200000, 24'h200000, 1'b1);
    $display("pdm done");
    out_ready_i <= 1'b0;
    for (int k = 1; k <= 5; k++)
      u_pdm.send(24'(k));
    u_pdm.idle();
    rchk(`REG_STATUS, 8'h03);
    check({23'h0, pdm_ready_o}, 24'h0);
    out_ready_i <= 1'b1;
    for (int k = 1; k <= 5; k++)
      take(24'(k), 1'b1);
    repeat (20) @(posedge clk_i);
    rchk(`REG_STATUS, 8'h00);
    got_q.delete();
    $display("buffer done");
    wr(`REG_CTRL, 8'h1e);
    wr(`REG_PCM_VOL, 8'h00);
    xfer(1'b0, 24'h0, 24'h0, 1'b0);
    repeat (30) xfer(1'b0, 24'h200000, 24'h0, 1'b0);
    check({23'h0, last_w < 24'h100000}, 24'h1);
    $display("filter done");
    wrap_up();
  end
endmodule
`default_nettype wire
